// [core/estl_params.svh]
// Purpose: Named constants for the emergency stop and trip logic.
// Assumes: Included by bare name; definitions only.
// Notes: Byte offsets are word aligned on the APB register map.
`ifndef ESTL_PARAMS_SVH
`define ESTL_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ESTL_ADDR_CTRL 12'h000
`define ESTL_ADDR_POL 12'h004
`define ESTL_ADDR_ALMSEL 12'h008
`define ESTL_ADDR_THRESH 12'h00C
`define ESTL_ADDR_STATUS 12'h010
`define ESTL_ADDR_IRQ_STAT 12'h014
`define ESTL_ADDR_IRQ_MASK 12'h018
`define ESTL_ADDR_RELAY 12'h01C
`define ESTL_ADDR_IN_BASE 12'h040
`define ESTL_ADDR_OUT_BASE 12'h060
// ----------------------------------------
// Fields, codes and reset values
// ----------------------------------------
`define ESTL_CTRL_RUN 0
`define ESTL_CTRL_PANEL_CLEAR 1
`define ESTL_TERM_RESET 0
`define ESTL_TERM_ESTOP 2
`define ESTL_FUNC_FAULT_CLEAR 7'h12
`define ESTL_FUNC_ESTOP 7'h40
`define ESTL_FUNC_NONE 7'h7F
`define ESTL_FUNC_IN3_RST 7'h06
`define ESTL_FUNC_OTHER_RST 7'h00
`define ESTL_OUT_FUNC_MAX 6'h32
`define ESTL_RELAY_FUNC_MAX 6'h2A
`define ESTL_OUT_FUNC_RUN 6'h00
`define ESTL_OUT_FUNC_ALARM 6'h05
`define ESTL_OUT_FUNC_ESTOP 6'h06
`define ESTL_OUT_FUNC_THERM 6'h07
`define ESTL_ALM_OFF 2'h0
`define ESTL_ALM_3BIT 2'h1
`define ESTL_ALM_4BIT 2'h2
`define ESTL_TRIP_CODE_NONE 6'h00
`define ESTL_TRIP_CODE_ESTOP 6'h25
`define ESTL_TRIP_CODE_THERM 6'h23
`define ESTL_ALM_IDX_NONE 4'h0
`define ESTL_ALM_IDX_ESTOP 4'h1
`define ESTL_ALM_IDX_THERM 4'h2
`define ESTL_THRESH_MAX 14'h270F
`define ESTL_THRESH_RST 14'h0BB8
`define ESTL_IRQ_ESTOP 0
`define ESTL_IRQ_THERM 1
`define ESTL_IRQ_CLEARED 2
`define ESTL_IRQ_SWITCH 3
`endif

// [core/estl_pkg.sv]
// Purpose: Shared types of the emergency stop and trip logic.
// Assumes: Constants live in estl_params.svh.
// Notes: Trip state is one-hot.
package estl_pkg;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_ESTOP = 3'b010,
    ST_THERM = 3'b100
  } estl_state_t;
  typedef logic [6:0] estl_in_func_t;
  typedef logic [5:0] estl_out_func_t;
endpackage

// [core/estl_sync.sv]
// Purpose: Two flop synchroniser for pin levels.
// Assumes: Inputs are slow contact levels, so per-bit sync suffices.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module estl_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  // Two stages, reset to contact open
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end
  assign Q = sync_reg;
endmodule
`default_nettype wire

// [core/estl_out_map.sv]
// Purpose: Maps status onto the open-collector outputs and the relay.
// Assumes: All inputs come from flops on the same clock.
// Notes: Combinational; the top registers the result.
`timescale 1ns/100ps
`default_nettype none
`include "estl_params.svh"
module estl_out_map
  import estl_pkg::*;
(
  input wire estl_pkg::estl_out_func_t OUT_FUNC [5],
  input wire estl_pkg::estl_out_func_t RELAY_FUNC,
  input wire logic [1:0] ALM_MODE,
  input wire logic [3:0] ALM_IDX,
  input wire logic RUNNING,
  input wire logic TRIPPED,
  input wire logic ESTOP_TRIP,
  input wire logic THERM_TRIP,
  output logic [4:0] OC,
  output logic RELAY
);
  // Selects one status signal by function code
  function automatic logic fsel(input estl_out_func_t code, input logic run, input logic trip,
                                input logic est, input logic thm);
    logic r;
    r = 1'b0;
    case (code)
      `ESTL_OUT_FUNC_RUN: r = run;
      `ESTL_OUT_FUNC_ALARM: r = trip;
      `ESTL_OUT_FUNC_ESTOP: r = est;
      `ESTL_OUT_FUNC_THERM: r = thm;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [4:0] plain;
  wire code3 = (ALM_MODE == `ESTL_ALM_3BIT);
  wire code4 = (ALM_MODE == `ESTL_ALM_4BIT);

  // Per-terminal function outputs
  always_comb begin
    plain = 5'h00;
    for (int i = 0; i < 5; i++) begin
      plain[i] = fsel(OUT_FUNC[i], RUNNING, TRIPPED, ESTOP_TRIP, THERM_TRIP);
    end
  end

  // Alarm code takes terminals exclusively, low bit on first terminal
  assign OC[2:0] = (code3 | code4) ? ALM_IDX[2:0] : plain[2:0];
  assign OC[3] = code4 ? ALM_IDX[3] : plain[3];
  assign OC[4] = plain[4];
  assign RELAY = fsel(RELAY_FUNC, RUNNING, TRIPPED, ESTOP_TRIP, THERM_TRIP);
endmodule
`default_nettype wire

// [core/estl_top.sv]
// Purpose: Emergency stop, trip latch and terminal function logic.
// Assumes: Contact pins read 1 while the contact is closed.
// Notes: Output gating never waits on software.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "estl_params.svh"
module estl_top
  import estl_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int PWM_W = 6
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_IN-1:0] IN_TERM,
  input wire logic ESTOP_ENABLE_SWITCH,
  input wire logic [13:0] EXT_TEMP_OHMS,
  input wire logic [PWM_W-1:0] PWM_REQ,
  output logic [PWM_W-1:0] PWM_OUT,
  output logic [4:0] OC_OUT,
  output logic RELAY_OUT,
  output logic IRQ
);
  import estl_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [NUM_IN-1:0] in_s;
  logic sw_s;
  logic sw_prev_reg;

  estl_sync #(.W(NUM_IN)) u_sync_in (
    .CLK(CLK),
    .RST(RST),
    .D(IN_TERM),
    .Q(in_s)
  );

  estl_sync #(.W(1)) u_sync_sw (
    .CLK(CLK),
    .RST(RST),
    .D(ESTOP_ENABLE_SWITCH),
    .Q(sw_s)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  estl_in_func_t in_func_reg [NUM_IN];
  estl_out_func_t out_func_reg [5];
  estl_out_func_t relay_func_reg;
  logic [NUM_IN-1:0] pol_reg;
  logic [1:0] alm_sel_reg;
  logic [13:0] thresh_reg;
  logic run_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [PWM_W-1:0] pwm_out_reg;
  logic [4:0] oc_reg;
  logic relay_reg;
  estl_state_t state_reg;
  estl_state_t state_next;

  // ----------------------------------------
  // Switch edges and terminal meaning
  // ----------------------------------------
  wire sw_rise = sw_s & ~sw_prev_reg;
  wire sw_fall = ~sw_s & sw_prev_reg;
  // Function lives only while the switch is seen on
  wire estop_on = sw_s;
  // Closed contact on terminal 1 asserts reset, fixed NO
  wire fault_clear_input = in_s[`ESTL_TERM_RESET];
  // Fixed NC: an open, broken or miswired line reads as stop
  wire estop_input = ~in_s[`ESTL_TERM_ESTOP];
  wire stop_req = estop_on & estop_input;
  wire [NUM_IN-1:0] term_active = in_s ^ pol_reg;

  // Reset input: dedicated terminal when enabled, any fault clear terminal otherwise
  logic any_clear;
  always_comb begin
    any_clear = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (in_func_reg[i] == `ESTL_FUNC_FAULT_CLEAR && term_active[i]) begin
        any_clear = 1'b1;
      end
    end
  end
  wire reset_in = estop_on ? fault_clear_input : any_clear;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr_en = PSEL & PENABLE & PWRITE;
  wire [11:0] in_off = PADDR - `ESTL_ADDR_IN_BASE;
  wire [11:0] out_off = PADDR - `ESTL_ADDR_OUT_BASE;
  wire hit_in = (PADDR >= `ESTL_ADDR_IN_BASE) && (in_off[11:2] < NUM_IN[9:0]) && (PADDR[1:0] == 2'h0);
  wire hit_out = (PADDR >= `ESTL_ADDR_OUT_BASE) && (out_off[11:2] < 10'h005) && (PADDR[1:0] == 2'h0);
  wire [2:0] in_idx = in_off[4:2];
  wire [2:0] out_idx = out_off[4:2];
  wire hit_fixed = (PADDR == `ESTL_ADDR_CTRL) || (PADDR == `ESTL_ADDR_POL) ||
                   (PADDR == `ESTL_ADDR_ALMSEL) || (PADDR == `ESTL_ADDR_THRESH) ||
                   (PADDR == `ESTL_ADDR_STATUS) || (PADDR == `ESTL_ADDR_IRQ_STAT) ||
                   (PADDR == `ESTL_ADDR_IRQ_MASK) || (PADDR == `ESTL_ADDR_RELAY);
  wire mapped = hit_fixed | hit_in | hit_out;
  // Dedicated terminals are locked while enabled; the stop function is never writable
  wire in_locked = estop_on && (in_idx == 3'(`ESTL_TERM_RESET) || in_idx == 3'(`ESTL_TERM_ESTOP));
  wire in_bad = hit_in && (in_locked || PWDATA[6:0] == `ESTL_FUNC_ESTOP);
  wire out_bad = hit_out && (PWDATA[5:0] > `ESTL_OUT_FUNC_MAX);
  wire relay_bad = (PADDR == `ESTL_ADDR_RELAY) && (PWDATA[5:0] > `ESTL_RELAY_FUNC_MAX);
  wire thr_bad = (PADDR == `ESTL_ADDR_THRESH) && (PWDATA[13:0] > `ESTL_THRESH_MAX);
  wire wr_bad = PWRITE && (in_bad || out_bad || relay_bad || thr_bad || PADDR == `ESTL_ADDR_STATUS);
  wire err = ~mapped | wr_bad;
  wire wr_ok = wr_en & ~pslverr_reg;
  wire panel_clear = wr_ok && (PADDR == `ESTL_ADDR_CTRL) && PWDATA[`ESTL_CTRL_PANEL_CLEAR];

  // ----------------------------------------
  // Trip state
  // ----------------------------------------
  wire therm_over = EXT_TEMP_OHMS > thresh_reg;
  wire estop_trip = (state_reg == ST_ESTOP);
  wire therm_trip = (state_reg == ST_THERM);
  wire tripped = estop_trip | therm_trip;

  // Stop beats everything; stop trip ignores the panel clear
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: begin
        if (stop_req) begin
          state_next = ST_ESTOP;
        end else if (therm_over) begin
          state_next = ST_THERM;
        end
      end
      ST_THERM: begin
        if (stop_req) begin
          state_next = ST_ESTOP;
        end else if ((reset_in | panel_clear) && !therm_over) begin
          state_next = ST_READY;
        end
      end
      ST_ESTOP: begin
        // Held until terminal 1 reset with the stop withdrawn, or any fault clear terminal while the switch is off
        if (estop_on && fault_clear_input && !stop_req) begin
          state_next = therm_over ? ST_THERM : ST_READY;
        end else if (!estop_on && reset_in) begin
          state_next = therm_over ? ST_THERM : ST_READY;
        end
      end
      default: state_next = ST_ESTOP;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output gating straight from the stop input as well as from the state register
  wire gate_ok = run_reg & ~stop_req & ~tripped;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwm_out_reg <= '0;
    end else begin
      pwm_out_reg <= gate_ok ? PWM_REQ : '0;
    end
  end

  // ----------------------------------------
  // Input terminal function table
  // ----------------------------------------
  // Switch edges override software writes in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sw_prev_reg <= 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
        in_func_reg[i] <= `ESTL_FUNC_OTHER_RST;
      end
      in_func_reg[`ESTL_TERM_RESET] <= `ESTL_FUNC_FAULT_CLEAR;
      in_func_reg[`ESTL_TERM_ESTOP] <= `ESTL_FUNC_IN3_RST;
      pol_reg <= '0;
    end else begin
      sw_prev_reg <= sw_s;
      if (wr_ok && hit_in) begin
        in_func_reg[in_idx] <= PWDATA[6:0];
      end
      if (wr_ok && PADDR == `ESTL_ADDR_POL) begin
        pol_reg <= PWDATA[NUM_IN-1:0];
        if (estop_on) begin
          pol_reg[`ESTL_TERM_RESET] <= pol_reg[`ESTL_TERM_RESET];
          pol_reg[`ESTL_TERM_ESTOP] <= pol_reg[`ESTL_TERM_ESTOP];
        end
      end
      if (sw_rise) begin
        for (int i = 0; i < NUM_IN; i++) begin
          if (in_func_reg[i] == `ESTL_FUNC_FAULT_CLEAR) begin
            in_func_reg[i] <= `ESTL_FUNC_NONE;
          end
        end
        in_func_reg[`ESTL_TERM_RESET] <= `ESTL_FUNC_FAULT_CLEAR;
        in_func_reg[`ESTL_TERM_ESTOP] <= `ESTL_FUNC_ESTOP;
        pol_reg[`ESTL_TERM_RESET] <= 1'b0;
        pol_reg[`ESTL_TERM_ESTOP] <= 1'b1;
      end
      if (sw_fall) begin
        in_func_reg[`ESTL_TERM_ESTOP] <= `ESTL_FUNC_NONE;
      end
    end
  end

  // ----------------------------------------
  // Control, output and threshold registers
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_reg <= 1'b0;
      alm_sel_reg <= `ESTL_ALM_OFF;
      thresh_reg <= `ESTL_THRESH_RST;
      relay_func_reg <= `ESTL_OUT_FUNC_ALARM;
      irq_mask_reg <= 4'h0;
      for (int i = 0; i < 5; i++) begin
        out_func_reg[i] <= `ESTL_OUT_FUNC_RUN;
      end
    end else begin
      if (wr_ok && PADDR == `ESTL_ADDR_CTRL) begin
        run_reg <= PWDATA[`ESTL_CTRL_RUN];
      end
      if (wr_ok && PADDR == `ESTL_ADDR_ALMSEL) begin
        alm_sel_reg <= PWDATA[1:0];
      end
      if (wr_ok && PADDR == `ESTL_ADDR_THRESH) begin
        thresh_reg <= PWDATA[13:0];
      end
      if (wr_ok && PADDR == `ESTL_ADDR_RELAY) begin
        relay_func_reg <= PWDATA[5:0];
      end
      if (wr_ok && PADDR == `ESTL_ADDR_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[3:0];
      end
      if (wr_ok && hit_out) begin
        out_func_reg[out_idx] <= PWDATA[5:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------
  wire [3:0] irq_evt;
  assign irq_evt[`ESTL_IRQ_ESTOP] = (state_next == ST_ESTOP) && !estop_trip;
  assign irq_evt[`ESTL_IRQ_THERM] = (state_next == ST_THERM) && !therm_trip;
  assign irq_evt[`ESTL_IRQ_CLEARED] = (state_next == ST_READY) && tripped;
  assign irq_evt[`ESTL_IRQ_SWITCH] = sw_rise | sw_fall;
  wire [3:0] irq_w1c = (wr_ok && PADDR == `ESTL_ADDR_IRQ_STAT) ? PWDATA[3:0] : 4'h0;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_evt;
    end
  end
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Terminal outputs
  // ----------------------------------------
  // Trip cause as a small binary index
  function automatic logic [3:0] alm_idx(input estl_state_t st);
    logic [3:0] r;
    r = `ESTL_ALM_IDX_NONE;
    case (st)
      ST_ESTOP: r = `ESTL_ALM_IDX_ESTOP;
      ST_THERM: r = `ESTL_ALM_IDX_THERM;
      default: r = `ESTL_ALM_IDX_NONE;
    endcase
    return r;
  endfunction

  wire [4:0] oc_map;
  wire relay_map;
  estl_out_map u_out_map (
    .OUT_FUNC(out_func_reg),
    .RELAY_FUNC(relay_func_reg),
    .ALM_MODE(alm_sel_reg),
    .ALM_IDX(alm_idx(state_reg)),
    .RUNNING(gate_ok),
    .TRIPPED(tripped),
    .ESTOP_TRIP(estop_trip),
    .THERM_TRIP(therm_trip),
    .OC(oc_map),
    .RELAY(relay_map)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      oc_reg <= 5'h00;
      relay_reg <= 1'b0;
    end else begin
      oc_reg <= oc_map;
      relay_reg <= relay_map;
    end
  end

  // ----------------------------------------
  // Read path, latched in the setup cycle
  // ----------------------------------------
  wire [5:0] trip_code = estop_trip ? `ESTL_TRIP_CODE_ESTOP :
                         therm_trip ? `ESTL_TRIP_CODE_THERM : `ESTL_TRIP_CODE_NONE;
  wire [31:0] status_word = {16'h0000, 2'h0, trip_code, 4'h0, stop_req, sw_s, therm_trip, estop_trip};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_in) begin
      rd_mux = {25'h0000000, in_func_reg[in_idx]};
    end else if (hit_out) begin
      rd_mux = {26'h0000000, out_func_reg[out_idx]};
    end else begin
      case (PADDR)
        `ESTL_ADDR_CTRL: rd_mux = {31'h00000000, run_reg};
        `ESTL_ADDR_POL: rd_mux = {{(32 - NUM_IN){1'b0}}, pol_reg};
        `ESTL_ADDR_ALMSEL: rd_mux = {30'h00000000, alm_sel_reg};
        `ESTL_ADDR_THRESH: rd_mux = {18'h00000, thresh_reg};
        `ESTL_ADDR_STATUS: rd_mux = status_word;
        `ESTL_ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_reg};
        `ESTL_ADDR_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_reg};
        `ESTL_ADDR_RELAY: rd_mux = {26'h0000000, relay_func_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= PWRITE ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= err;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & pslverr_reg;
  assign PWM_OUT = pwm_out_reg;
  assign OC_OUT = oc_reg;
  assign RELAY_OUT = relay_reg;
endmodule
`default_nettype wire

// [verification/estl_top_properties.sv]
// Purpose: Port properties of the stop and trip logic.
// Assumes: Bound onto estl_top from the bench top file.
// Notes: A helper flop remembers a stop trip until a reset press.
`timescale 1ns/100ps
`default_nettype none
module estl_top_checker #(
  parameter int NUM_IN = 8,
  parameter int PWM_W = 6
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [NUM_IN-1:0] IN_TERM,
  input wire logic ESTOP_ENABLE_SWITCH,
  input wire logic [13:0] EXT_TEMP_OHMS,
  input wire logic [PWM_W-1:0] PWM_REQ,
  input wire logic [PWM_W-1:0] PWM_OUT,
  input wire logic [4:0] OC_OUT,
  input wire logic RELAY_OUT,
  input wire logic IRQ
);
  // ----------------------------------------
  // Stop trip tracker
  // ----------------------------------------
  logic [1:0] cnt_reg;
  logic seen_reg;
  wire logic stop_pin;
  // Open stop contact while the switch is on
  assign stop_pin = ESTOP_ENABLE_SWITCH & ~IN_TERM[2];
  // Four samples cover the pin synchronisers, so a trip is certain
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= 2'h0;
      seen_reg <= 1'h0;
    end else begin
      cnt_reg <= stop_pin ? (cnt_reg == 2'h3 ? cnt_reg : cnt_reg + 2'h1) : 2'h0;
      seen_reg <= ~IN_TERM[0] & (seen_reg | (stop_pin & cnt_reg == 2'h3));
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
  a_write_zero: assert property (PSEL && PENABLE && PWRITE |-> PRDATA == 32'h0) else $error("read data on write");
  a_pwm_follow: assert property (PWM_OUT != '0 |-> PWM_OUT == $past(PWM_REQ)) else $error("gate data wrong");
  a_stop_gate: assert property (stop_pin [*4] |=> PWM_OUT == '0) else $error("stop not gated");
  a_trip_latch: assert property (seen_reg |-> PWM_OUT == '0) else $error("stop trip released");
  a_relay_alarm: assert property (seen_reg && $past(seen_reg) |-> RELAY_OUT) else $error("no relay alarm");
  a_rst_quiet: assert property ($fell(RST) |-> PWM_OUT == '0 && OC_OUT == 5'h0) else $error("outputs after reset");
endmodule
`default_nettype wire

// [verification/estl_contacts.sv]
// Purpose: Wired contacts and safety circuit at the input terminals.
// Assumes: Stop contact normally closed, reset contact normally open.
// Notes: A cut cable carries no current, so it reads as open.
`timescale 1ns/100ps
`default_nettype none
module estl_contacts (
  input wire logic clk,
  input wire logic stop_press,
  input wire logic cut,
  input wire logic clear_press,
  output logic [7:0] in_term
);
  // Stop loop closed and all else open at power up
  initial in_term = 8'h04;
  // Contacts move just after an edge
  always @(posedge clk) begin
    in_term[0] <= clear_press;
    in_term[1] <= 1'h0;
    in_term[2] <= ~(stop_press | cut);
    in_term[7:3] <= 5'h00;
  end
endmodule
`default_nettype wire

// [verification/test_estl_top.sv]
// Purpose: Self-checking bench for the stop and trip logic.
// Assumes: 100 MHz clock; zero-wait APB slave.
// Notes: Register cases come from a table; trips are written out.
`timescale 1ns/100ps
`default_nettype none
module test_estl_top;
  import estl_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e; logic [31:0] rb; logic rd;} estl_row_t;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic sw = 1'h0, stop_press = 1'h0, cut = 1'h0, clear_press = 1'h0, pready, pslverr, relay, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] in_term;
  logic [13:0] ohms = 14'h0000;
  logic [5:0] pwm_req = 6'h00, pwm_out;
  logic [4:0] oc;
  int failures = 0, n_compared = 0, k;
  // Address, data, refused, read back, read allowed
  estl_row_t rows [12] = '{'{12'h00C, 32'h270F, 1'h0, 32'h270F, 1'h1}, '{12'h00C, 32'h2710, 1'h1, 32'h270F, 1'h1},
    '{12'h070, 32'h32, 1'h0, 32'h32, 1'h1}, '{12'h070, 32'h33, 1'h1, 32'h32, 1'h1},
    '{12'h01C, 32'h2B, 1'h1, 32'h05, 1'h1}, '{12'h01C, 32'h05, 1'h0, 32'h05, 1'h1},
    '{12'h010, 32'h1, 1'h1, 32'h0, 1'h1}, '{12'h044, 32'h40, 1'h1, 32'h0, 1'h1},
    '{12'h044, 32'h12, 1'h0, 32'h12, 1'h1}, '{12'h008, 32'h2, 1'h0, 32'h2, 1'h1},
    '{12'h100, 32'h0, 1'h1, 32'h0, 1'h0}, '{12'h002, 32'h0, 1'h1, 32'h0, 1'h0}};
  // ----------------------------------------
  // Design, contacts and clock
  // ----------------------------------------
  estl_top #(.NUM_IN(8), .PWM_W(6)) u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IN_TERM(in_term), .ESTOP_ENABLE_SWITCH(sw), .EXT_TEMP_OHMS(ohms), .PWM_REQ(pwm_req),
    .PWM_OUT(pwm_out), .OC_OUT(oc), .RELAY_OUT(relay), .IRQ(irq));
  estl_contacts u_contacts (.clk(clk), .stop_press(stop_press), .cut(cut), .clear_press(clear_press),
    .in_term(in_term));
  always #5 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; an idle edge first keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n == 50) begin
      failures++;
      complete_run();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, q, e);
    check(q, x);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 12; i++) begin
      apb(1'h1, rows[i].a, rows[i].d, q, e);
      check(32'(e), 32'(rows[i].e));
      apb(1'h0, rows[i].a, 32'h0, q, e);
      if (rows[i].rd) check(q, rows[i].rb);
    end
    $display("register table done");
    // Second reset mid-run restores defaults
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(12'h01C, 32'h05);
    rd(12'h00C, 32'hBB8);
    rd(12'h040, 32'h12);
    rd(12'h010, 32'h0);
    $display("reset test done");
    // Open stop input is ignored while the switch is off
    wr(12'h000, 32'h1);
    wr(12'h044, 32'h12);
    wr(12'h008, 32'h1);
    wr(12'h018, 32'h1);
    pwm_req <= 6'h2A;
    cut <= 1'h1;
    repeat (8) @(posedge clk);
    check(32'(pwm_out), 32'h2A);
    check(32'(oc), 32'h18);
    cut <= 1'h0;
    // Let the closed stop loop pass the synchronisers before the switch goes on
    repeat (4) @(posedge clk);
    sw <= 1'h1;
    repeat (8) @(posedge clk);
    rd(12'h044, 32'h7F);
    rd(12'h048, 32'h40);
    wr(12'h040, 32'h7F);
    check(32'(e), 32'h1);
    check(32'(pwm_out), 32'h2A);
    // Stop press trips, panel clear is ignored, latch holds
    stop_press <= 1'h1;
    k = 0;
    while (pwm_out !== 6'h00 && k < 12) begin
      @(posedge clk);
      k++;
    end
    check(32'(k < 12), 32'h1);
    if (k == 12) complete_run();
    repeat (3) @(posedge clk);
    rd(12'h010, 32'h250D);
    check(32'(irq), 32'h1);
    check(32'(relay), 32'h1);
    check(32'(oc), 32'h01);
    wr(12'h000, 32'h3);
    stop_press <= 1'h0;
    repeat (8) @(posedge clk);
    rd(12'h010, 32'h2505);
    check(32'(pwm_out), 32'h0);
    wr(12'h014, 32'h1);
    @(posedge clk);
    check(32'(irq), 32'h0);
    clear_press <= 1'h1;
    repeat (6) @(posedge clk);
    clear_press <= 1'h0;
    repeat (6) @(posedge clk);
    rd(12'h010, 32'h4);
    check(32'(pwm_out), 32'h2A);
    $display("stop trip test done");
    // Cut cable trips the same way
    cut <= 1'h1;
    repeat (8) @(posedge clk);
    rd(12'h010, 32'h250D);
    cut <= 1'h0;
    clear_press <= 1'h1;
    repeat (6) @(posedge clk);
    clear_press <= 1'h0;
    sw <= 1'h0;
    repeat (8) @(posedge clk);
    rd(12'h048, 32'h7F);
    rd(12'h040, 32'h12);
    rd(12'h044, 32'h7F);
    $display("switch test done");
    // Thermistor one ohm above the threshold
    ohms <= 14'h0BB9;
    repeat (4) @(posedge clk);
    rd(12'h010, 32'h2302);
    check(32'(pwm_out), 32'h0);
    check(32'(oc), 32'h02);
    rd(12'h014, 32'hF);
    // Back at the threshold, the panel may clear a thermistor trip
    ohms <= 14'h0BB8;
    wr(12'h000, 32'h3);
    rd(12'h010, 32'h0);
    $display("thermistor test done");
    complete_run();
  end
endmodule
bind estl_top estl_top_checker #(.NUM_IN(NUM_IN), .PWM_W(PWM_W)) u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IN_TERM(IN_TERM), .ESTOP_ENABLE_SWITCH(ESTOP_ENABLE_SWITCH),
  .EXT_TEMP_OHMS(EXT_TEMP_OHMS), .PWM_REQ(PWM_REQ), .PWM_OUT(PWM_OUT), .OC_OUT(OC_OUT),
  .RELAY_OUT(RELAY_OUT), .IRQ(IRQ));
`default_nettype wire
